/* File: design/bgcr_pkg.sv */
// Constants, types and field layouts for the bridge global control registers.
// Assumes a configuration-space access port clocked by the PCI clock.
package bgcr_pkg;

   // -------------------------------------------------
   // Register offsets (configuration-space byte addresses)
   // -------------------------------------------------
   localparam logic [7:0] OFS_DEVICE_CONTROL = 8'h92;
   localparam logic [7:0] OFS_DIAGNOSTIC_CONTROL = 8'h93;
   localparam logic [7:0] OFS_SOCKET_DMA = 8'h94;
   localparam logic [7:0] OFS_VENDOR_DEVICE_ID = 8'h00;

   // -------------------------------------------------
   // Reset values
   // -------------------------------------------------
   localparam logic [7:0] RST_DEVICE_CONTROL = 8'h66;
   localparam logic [7:0] RST_DIAGNOSTIC_CONTROL = 8'h61;
   localparam logic [1:0] RST_DMA_PIN_SEL = 2'h0;

   // -------------------------------------------------
   // Device control field positions
   // -------------------------------------------------
   localparam int DC_POWER_LOCK = 7;
   localparam int DC_LV_FORCE = 6;
   localparam int DC_DIAG5 = 5;
   localparam int DC_RSVD4 = 4;
   localparam int DC_TEST = 3;
   localparam int DC_MODE_HI = 2;
   localparam int DC_MODE_LO = 1;
   localparam int DC_NAND_EN = 0;
   localparam logic [7:0] DC_WRITE_MASK = 8'hef;

   // -------------------------------------------------
   // Diagnostic field positions
   // -------------------------------------------------
   localparam int DG_ID_MASK = 7;
   localparam int DG_CSC_ROUTE = 5;
   localparam int DG_DELAY_DIS = 4;
   localparam int DG_RETRY_LATENCY_EXTEND = 3;
   localparam int DG_CB_DISCARD = 2;
   localparam int DG_PCI_DISCARD = 1;
   localparam int DG_ASYNC_STATUS_CHANGE_IRQ = 0;

   // -------------------------------------------------
   // Timing counts in PCI clocks
   // -------------------------------------------------
   localparam int RETRY_LAT_NORMAL = 16;
   localparam int RETRY_LAT_EXT = 64;
   localparam int DISCARD_LOG2_SHORT = 10;
   localparam int DISCARD_LOG2_LONG = 15;
   localparam int RETRY_EXPIRE_LOG2 = 15;

   // -------------------------------------------------
   // Enumerations
   // -------------------------------------------------
   typedef enum logic [1:0] {
      IRQ_PARALLEL_ONLY = 2'h0,
      IRQ_RESERVED = 2'h1,
      IRQ_SERIAL_PLUS_INTAB = 2'h2,
      IRQ_SERIAL_ALL = 2'h3
   } bgcr_irq_mode_e;

   typedef enum logic [1:0] {
      DMA_PIN_NONE = 2'h0,
      DMA_PIN_SPEAKER = 2'h1,
      DMA_PIN_IO16 = 2'h2,
      DMA_PIN_INPUT_ACKNOWLEDGE_PIN = 2'h3
   } bgcr_dma_pin_e;

   // Configuration access request
   typedef struct packed {
      logic rd;
      logic wr;
      logic func1;
      logic [7:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } bgcr_cfg_req_s;

   // Controls decoded for the rest of the bridge
   typedef struct packed {
      logic power_lock;
      logic low_voltage_capable_force;
      logic diagnostic_field_bit_five;
      logic test_short_interrogate;
      bgcr_irq_mode_e irq_signalling_mode;
      logic nand_tree_en;
      logic id_mask;
      logic csc_route_by_805;
      logic delayed_txn_disable;
      logic retry_latency_extend;
      logic card_side_discard_timer_sel;
      logic host_side_discard_timer_sel;
      logic async_status_change_irq;
   } bgcr_ctrl_s;

endpackage

/* File: design/bgcr_regs.sv */
// Global control, diagnostic and socket DMA request registers of the bridge.
// Assumes a single-cycle configuration access port on the PCI clock;
// per-function true ID and compatibility register bits come from elsewhere.
`timescale 1ns/1ps

module bgcr_regs #(
   parameter int SOCKETS = 2
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   // Configuration access
   input wire bgcr_pkg::bgcr_cfg_req_s cfg_req_i,
   input wire logic [31:0] true_id_i,
   output logic [31:0] cfg_rdata_o,
   output logic cfg_hit_o,
   // Power management
   input wire logic d3_state_i,
   input wire logic sw_power_down_req_i,
   output logic socket_power_down_o,
   // Status change routing inputs
   input wire logic compat803_bit4_i,
   input wire logic [3:0] compat805_hi_i,
   output logic csc_to_pci_o,
   // Retry watch
   input wire logic retry_pending_i,
   input wire logic retry_returned_i,
   output logic retry_expired_o,
   output logic [6:0] retry_latency_o,
   output logic [15:0] cb_discard_cycles_o,
   output logic [15:0] pci_discard_cycles_o,
   // Socket pins used as DMA request
   input wire logic [SOCKETS-1:0] speaker_pin_i,
   input wire logic [SOCKETS-1:0] io_width16_indicator_pin_i,
   input wire logic [SOCKETS-1:0] input_acknowledge_pin_i,
   output logic [SOCKETS-1:0] dma_request_o,
   output logic [SOCKETS-1:0] speaker_normal_o,
   output logic [SOCKETS-1:0] io16_normal_o,
   output logic [SOCKETS-1:0] input_acknowledge_pin_normal_o,
   // Decoded controls
   output bgcr_pkg::bgcr_ctrl_s ctrl_o
);

   // Only one or two sockets have a DMA request field to serve
   if (SOCKETS < 1 || SOCKETS > 2) begin
      $error("SOCKETS must be 1 or 2");
   end

   // -------------------------------------------------
   // Storage
   // -------------------------------------------------
   localparam int RETRY_CNT_W = bgcr_pkg::RETRY_EXPIRE_LOG2 + 1;

   logic [7:0] dev_ctrl_r;
   logic [7:0] diagnostic_field_r;
   logic [1:0] dma_sel_r [SOCKETS];
   logic [RETRY_CNT_W-1:0] retry_cnt_r;
   logic retry_expired_r;
   logic [SOCKETS-1:0] spk_s1_r, spk_s2_r, io16_s1_r, io16_s2_r, inp_s1_r, inp_s2_r;
   logic [31:0] rdata_nxt;
   logic hit_nxt;
   logic [31:0] rdata_r;
   logic hit_r;

   // Socket index of an access: function number selects socket
   function automatic int sock_of(input logic func1);
      return (func1 && SOCKETS > 1) ? 1 : 0;
   endfunction

   function automatic logic wr_hit(input bgcr_pkg::bgcr_cfg_req_s r, input logic [7:0] ofs);
      return r.wr && (r.addr == ofs);
   endfunction

   // -------------------------------------------------
   // Device control: one copy for both functions
   // -------------------------------------------------
   // Writes from either function land in the same flops; software is
   // expected to use function 0 only.
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         dev_ctrl_r <= bgcr_pkg::RST_DEVICE_CONTROL;
      end else if (clk_en_i && wr_hit(cfg_req_i, bgcr_pkg::OFS_DEVICE_CONTROL)
                   && cfg_req_i.be[0]) begin
         dev_ctrl_r <= cfg_req_i.wdata[7:0] & bgcr_pkg::DC_WRITE_MASK;
      end
   end

   // Diagnostic register, shared as well
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         diagnostic_field_r <= bgcr_pkg::RST_DIAGNOSTIC_CONTROL;
      end else if (clk_en_i && wr_hit(cfg_req_i, bgcr_pkg::OFS_DIAGNOSTIC_CONTROL)
                   && cfg_req_i.be[0]) begin
         diagnostic_field_r <= cfg_req_i.wdata[7:0];
      end
   end

   // Per-socket DMA request pin field, one per function
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         for (int s = 0; s < SOCKETS; s++) begin
            dma_sel_r[s] <= bgcr_pkg::RST_DMA_PIN_SEL;
         end
      end else if (clk_en_i && wr_hit(cfg_req_i, bgcr_pkg::OFS_SOCKET_DMA)
                   && cfg_req_i.be[0]) begin
         dma_sel_r[sock_of(cfg_req_i.func1)] <= cfg_req_i.wdata[1:0];
      end
   end

   // -------------------------------------------------
   // Read path
   // -------------------------------------------------
   // Registers 92h/93h are addressed by byte; their data rides byte lane 0.
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      hit_nxt = 1'b0;
      if (cfg_req_i.rd) begin
         unique case (cfg_req_i.addr)
            bgcr_pkg::OFS_DEVICE_CONTROL: begin
               rdata_nxt = {24'h00_0000, dev_ctrl_r};
               hit_nxt = 1'b1;
            end
            bgcr_pkg::OFS_DIAGNOSTIC_CONTROL: begin
               rdata_nxt = {24'h00_0000, diagnostic_field_r};
               hit_nxt = 1'b1;
            end
            bgcr_pkg::OFS_SOCKET_DMA: begin
               rdata_nxt = {30'h0000_0000, dma_sel_r[sock_of(cfg_req_i.func1)]};
               hit_nxt = 1'b1;
            end
            bgcr_pkg::OFS_VENDOR_DEVICE_ID: begin
               // Masking hides identity during board bring-up tests
               rdata_nxt = diagnostic_field_r[bgcr_pkg::DG_ID_MASK] ? 32'hffff_ffff : true_id_i;
               hit_nxt = 1'b1;
            end
            default: begin
               rdata_nxt = 32'h0000_0000;
               hit_nxt = 1'b0;
            end
         endcase
      end
   end

   // Registered read data, answer one cycle after the request
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         rdata_r <= 32'h0000_0000;
         hit_r <= 1'b0;
      end else if (clk_en_i) begin
         rdata_r <= rdata_nxt;
         hit_r <= hit_nxt;
      end
   end

   assign cfg_rdata_o = rdata_r;
   assign cfg_hit_o = hit_r;

   // -------------------------------------------------
   // Decoded controls
   // -------------------------------------------------
   always_comb begin
      ctrl_o.power_lock = dev_ctrl_r[bgcr_pkg::DC_POWER_LOCK];
      ctrl_o.low_voltage_capable_force = dev_ctrl_r[bgcr_pkg::DC_LV_FORCE];
      ctrl_o.diagnostic_field_bit_five = dev_ctrl_r[bgcr_pkg::DC_DIAG5];
      ctrl_o.test_short_interrogate = dev_ctrl_r[bgcr_pkg::DC_TEST];
      ctrl_o.irq_signalling_mode =
         bgcr_pkg::bgcr_irq_mode_e'(dev_ctrl_r[bgcr_pkg::DC_MODE_HI:bgcr_pkg::DC_MODE_LO]);
      ctrl_o.nand_tree_en = dev_ctrl_r[bgcr_pkg::DC_NAND_EN];
      ctrl_o.id_mask = diagnostic_field_r[bgcr_pkg::DG_ID_MASK];
      ctrl_o.csc_route_by_805 = diagnostic_field_r[bgcr_pkg::DG_CSC_ROUTE];
      ctrl_o.delayed_txn_disable = diagnostic_field_r[bgcr_pkg::DG_DELAY_DIS];
      ctrl_o.retry_latency_extend = diagnostic_field_r[bgcr_pkg::DG_RETRY_LATENCY_EXTEND];
      ctrl_o.card_side_discard_timer_sel = diagnostic_field_r[bgcr_pkg::DG_CB_DISCARD];
      ctrl_o.host_side_discard_timer_sel = diagnostic_field_r[bgcr_pkg::DG_PCI_DISCARD];
      ctrl_o.async_status_change_irq = diagnostic_field_r[bgcr_pkg::DG_ASYNC_STATUS_CHANGE_IRQ];
   end

   // Power-down requests gated by the lock while in D3
   assign socket_power_down_o = sw_power_down_req_i
      && !(d3_state_i && dev_ctrl_r[bgcr_pkg::DC_POWER_LOCK]);

   // Status-change routing: compat 805 nibble or compat 803 bit 4
   assign csc_to_pci_o = diagnostic_field_r[bgcr_pkg::DG_CSC_ROUTE] ?
      (compat805_hi_i == 4'h0) : compat803_bit4_i;

   // Retry latency and discard periods
   assign retry_latency_o = diagnostic_field_r[bgcr_pkg::DG_RETRY_LATENCY_EXTEND] ?
      7'(bgcr_pkg::RETRY_LAT_EXT) : 7'(bgcr_pkg::RETRY_LAT_NORMAL);
   assign cb_discard_cycles_o = diagnostic_field_r[bgcr_pkg::DG_CB_DISCARD] ?
      16'(1 << bgcr_pkg::DISCARD_LOG2_SHORT) : 16'(1 << bgcr_pkg::DISCARD_LOG2_LONG);
   assign pci_discard_cycles_o = diagnostic_field_r[bgcr_pkg::DG_PCI_DISCARD] ?
      16'(1 << bgcr_pkg::DISCARD_LOG2_SHORT) : 16'(1 << bgcr_pkg::DISCARD_LOG2_LONG);

   // -------------------------------------------------
   // Retry expiration watch
   // -------------------------------------------------
   // Counts while a retried master is away; flags one clock after the count reaches 2^15.
   // The flag is sticky until the master returns or the retry stops pending.
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         retry_cnt_r <= '0;
         retry_expired_r <= 1'b0;
      end else if (clk_en_i) begin
         if (!retry_pending_i || retry_returned_i) begin
            retry_cnt_r <= '0;
            retry_expired_r <= 1'b0;
         end else if (!retry_cnt_r[RETRY_CNT_W-1]) begin
            retry_cnt_r <= retry_cnt_r + 1'b1;
         end else begin
            retry_expired_r <= 1'b1;
         end
      end
   end
   assign retry_expired_o = retry_expired_r;

   // -------------------------------------------------
   // Socket pin synchronisers and DMA request selection
   // -------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         spk_s1_r <= '0;
         spk_s2_r <= '0;
         io16_s1_r <= '0;
         io16_s2_r <= '0;
         inp_s1_r <= '0;
         inp_s2_r <= '0;
      end else if (clk_en_i) begin
         spk_s1_r <= speaker_pin_i;
         spk_s2_r <= spk_s1_r;
         io16_s1_r <= io_width16_indicator_pin_i;
         io16_s2_r <= io16_s1_r;
         inp_s1_r <= input_acknowledge_pin_i;
         inp_s2_r <= inp_s1_r;
      end
   end

   // Pin chosen as DMA request loses its normal function
   always_comb begin
      for (int s = 0; s < SOCKETS; s++) begin
         dma_request_o[s] = 1'b0;
         speaker_normal_o[s] = 1'b1;
         io16_normal_o[s] = 1'b1;
         input_acknowledge_pin_normal_o[s] = 1'b1;
         unique case (bgcr_pkg::bgcr_dma_pin_e'(dma_sel_r[s]))
            bgcr_pkg::DMA_PIN_NONE: dma_request_o[s] = 1'b0;
            bgcr_pkg::DMA_PIN_SPEAKER: begin
               dma_request_o[s] = spk_s2_r[s];
               speaker_normal_o[s] = 1'b0;
            end
            bgcr_pkg::DMA_PIN_IO16: begin
               dma_request_o[s] = io16_s2_r[s];
               io16_normal_o[s] = 1'b0;
            end
            bgcr_pkg::DMA_PIN_INPUT_ACKNOWLEDGE_PIN: begin
               dma_request_o[s] = inp_s2_r[s];
               input_acknowledge_pin_normal_o[s] = 1'b0;
            end
         endcase
      end
   end

   // -------------------------------------------------
   // Checks
   // -------------------------------------------------
   sequence s_dc_write;
      clk_en_i && cfg_req_i.wr && cfg_req_i.addr == bgcr_pkg::OFS_DEVICE_CONTROL && cfg_req_i.be[0];
   endsequence

   property p_lock_blocks;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (d3_state_i && dev_ctrl_r[7]) |-> !socket_power_down_o;
   endproperty
   a_lock_blocks: assert property (p_lock_blocks) else $error("power down passed lock");

   property p_rsvd4_zero;
      @(posedge mclk_i) disable iff (!rst_n_i)
      s_dc_write |=> dev_ctrl_r[4] == 1'b0 && dev_ctrl_r[6] == $past(cfg_req_i.wdata[6]);
   endproperty
   a_rsvd4_zero: assert property (p_rsvd4_zero) else $error("device control write wrong");

   property p_reset_values;
      @(posedge mclk_i) !rst_n_i |=> dev_ctrl_r == 8'h66 && diagnostic_field_r == 8'h61;
   endproperty
   a_reset_values: assert property (p_reset_values) else $error("bad reset value");

   property p_id_mask;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (clk_en_i && cfg_req_i.rd && cfg_req_i.addr == 8'h00 && diagnostic_field_r[7])
         |=> cfg_rdata_o == 32'hffff_ffff;
   endproperty
   a_id_mask: assert property (p_id_mask) else $error("id not masked");

   property p_csc_route;
      @(posedge mclk_i) disable iff (!rst_n_i)
      diagnostic_field_r[5] |-> csc_to_pci_o == (compat805_hi_i == 4'h0);
   endproperty
   a_csc_route: assert property (p_csc_route) else $error("status change route wrong");

   property p_retry_latency_extend;
      @(posedge mclk_i) disable iff (!rst_n_i)
      retry_latency_o == (diagnostic_field_r[3] ? 7'd64 : 7'd16);
   endproperty
   a_retry_latency_extend: assert property (p_retry_latency_extend) else $error("retry latency wrong");

   property p_discard;
      @(posedge mclk_i) disable iff (!rst_n_i)
      cb_discard_cycles_o == (diagnostic_field_r[2] ? 16'd1024 : 16'd32768)
      && pci_discard_cycles_o == (diagnostic_field_r[1] ? 16'd1024 : 16'd32768);
   endproperty
   a_discard: assert property (p_discard) else $error("discard period wrong");

   property p_dma_none;
      @(posedge mclk_i) disable iff (!rst_n_i)
      dma_sel_r[0] == 2'h0 |-> !dma_request_o[0] && speaker_normal_o[0]
         && io16_normal_o[0] && input_acknowledge_pin_normal_o[0];
   endproperty
   a_dma_none: assert property (p_dma_none) else $error("pin taken without selection");

   property p_dma_rd_zero;
      @(posedge mclk_i) disable iff (!rst_n_i)
      (clk_en_i && cfg_req_i.rd && cfg_req_i.addr == 8'h94) |=> cfg_rdata_o[31:2] == 30'h0;
   endproperty
   a_dma_rd_zero: assert property (p_dma_rd_zero) else $error("dma upper bits set");

   property p_retry_expire;
      @(posedge mclk_i) disable iff (!rst_n_i)
      retry_expired_o |-> retry_cnt_r == 16'h8000;
   endproperty
   a_retry_expire: assert property (p_retry_expire) else $error("early retry expiry");

endmodule

/* File: tb/bgcr_regs_bench.sv */
// Self-checking bench for the bridge global control registers.
// Assumes the design package is compiled first; the bench drives every port itself.
`timescale 1ns/1ps

module bgcr_regs_bench;
   // ---------------------------------------------
   // Signals and bench state
   // ---------------------------------------------
   localparam logic [7:0] A_DC = bgcr_pkg::OFS_DEVICE_CONTROL;
   localparam logic [7:0] A_DG = bgcr_pkg::OFS_DIAGNOSTIC_CONTROL;
   localparam logic [7:0] A_DMA = bgcr_pkg::OFS_SOCKET_DMA;
   localparam logic [7:0] A_ID = bgcr_pkg::OFS_VENDOR_DEVICE_ID;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic clk_en_i = 1'b1;
   bgcr_pkg::bgcr_cfg_req_s cfg_req_i = '0;
   logic [31:0] true_id_i = 32'h5a3c_9e17; // Arbitrary identity value
   logic [31:0] cfg_rdata_o;
   logic cfg_hit_o;
   logic d3_state_i = 1'b0;
   logic sw_power_down_req_i = 1'b0;
   logic socket_power_down_o;
   logic compat803_bit4_i = 1'b0;
   logic [3:0] compat805_hi_i = 4'h0;
   logic csc_to_pci_o;
   logic retry_pending_i = 1'b0;
   logic retry_returned_i = 1'b0;
   logic retry_expired_o;
   logic [6:0] retry_latency_o;
   logic [15:0] cb_discard_cycles_o;
   logic [15:0] pci_discard_cycles_o;
   logic [1:0] spk_pin = 2'h0;
   logic [1:0] io16_pin = 2'h0;
   logic [1:0] input_acknowledge_pin_pin = 2'h0;
   logic [1:0] dma_request_o;
   logic [1:0] speaker_normal_o;
   logic [1:0] io16_normal_o;
   logic [1:0] input_acknowledge_pin_normal_o;
   bgcr_pkg::bgcr_ctrl_s ctrl_o;
   int fail_count = 0;
   int compares = 0;
   int seed = 32'h4ff7;
   logic [7:0] v;
   logic [7:0] dc_exp;
   logic [7:0] dg;
   logic [31:0] d;

   // Free-running PCI clock, 8 ns period
   always #4 mclk_i = ~mclk_i;

   bgcr_regs #(.SOCKETS(2)) dut_u (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
      .cfg_req_i(cfg_req_i), .true_id_i(true_id_i),
      .cfg_rdata_o(cfg_rdata_o), .cfg_hit_o(cfg_hit_o),
      .d3_state_i(d3_state_i), .sw_power_down_req_i(sw_power_down_req_i),
      .socket_power_down_o(socket_power_down_o),
      .compat803_bit4_i(compat803_bit4_i), .compat805_hi_i(compat805_hi_i),
      .csc_to_pci_o(csc_to_pci_o),
      .retry_pending_i(retry_pending_i), .retry_returned_i(retry_returned_i),
      .retry_expired_o(retry_expired_o), .retry_latency_o(retry_latency_o),
      .cb_discard_cycles_o(cb_discard_cycles_o), .pci_discard_cycles_o(pci_discard_cycles_o),
      .speaker_pin_i(spk_pin), .io_width16_indicator_pin_i(io16_pin),
      .input_acknowledge_pin_i(input_acknowledge_pin_pin), .dma_request_o(dma_request_o),
      .speaker_normal_o(speaker_normal_o), .io16_normal_o(io16_normal_o),
      .input_acknowledge_pin_normal_o(input_acknowledge_pin_normal_o), .ctrl_o(ctrl_o)
   );

   // ---------------------------------------------
   // Shared tasks and expectation functions
   // ---------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t %s seen=%h exp=%h", $time, what, seen, exp);
      end
   endtask

   // One-cycle request; answer lands on the edge that takes it
   task automatic cfg(input logic rd, input logic wr, input logic f1, input logic [7:0] a,
                      input logic [31:0] wd);
      bgcr_pkg::bgcr_cfg_req_s r;
      r = '0;
      r.rd = rd;
      r.wr = wr;
      r.func1 = f1;
      r.addr = a;
      r.be = 4'h1;
      r.wdata = wd;
      @(posedge mclk_i);
      cfg_req_i <= r;
      @(posedge mclk_i);
      cfg_req_i <= '0;
      @(negedge mclk_i);
   endtask

   task automatic rd_chk(input logic f1, input logic [7:0] a, input logic [31:0] exp,
                         input logic hit);
      cfg(1'b1, 1'b0, f1, a, 32'h0);
      check(cfg_rdata_o, exp, "read data");
      check(cfg_hit_o, hit, "read hit");
   endtask

   function automatic logic exp_dma(input logic [1:0] sel, input logic s, input logic i,
                                    input logic p);
      case (sel)
         2'h1: exp_dma = s;
         2'h2: exp_dma = i;
         2'h3: exp_dma = p;
         default: exp_dma = 1'b0;
      endcase
   endfunction

   function automatic logic exp_csc(input logic by805, input logic b803, input logic [3:0] h805);
      exp_csc = by805 ? (h805 == 4'h0) : b803;
   endfunction

   task automatic tally_and_finish;
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Watchdog well past the long retry wait
   initial begin
      #(8 * 50000);
      fail_count++;
      tally_and_finish();
   end

   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      repeat (3) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      // Reset values, identity read and an unmapped offset
      rd_chk(1'b0, A_DC, 32'h66, 1'b1);
      rd_chk(1'b1, A_DG, 32'h61, 1'b1);
      rd_chk(1'b0, A_DMA, 32'h0, 1'b1);
      rd_chk(1'b0, A_ID, true_id_i, 1'b1);
      rd_chk(1'b0, 8'h95, 32'h0, 1'b0);
      // Random control values; device control written through one function, read through the other
      for (int k = 0; k < 12; k++) begin
         v = $random(seed);
         if (k == 0) v = 8'hff;
         if (k == 1) v = 8'h00;
         v[2:1] = k[1:0];
         v[3] = 1'b0; // Software keeps the test bit clear
         cfg(1'b0, 1'b1, k[0], A_DC, {$random(seed)} & 32'hffff_ff00 | {24'h0, v});
         dc_exp = v & bgcr_pkg::DC_WRITE_MASK;
         rd_chk(~k[0], A_DC, {24'h0, dc_exp}, 1'b1);
         check({ctrl_o.power_lock, ctrl_o.low_voltage_capable_force, ctrl_o.diagnostic_field_bit_five,
                ctrl_o.test_short_interrogate, ctrl_o.irq_signalling_mode,
                ctrl_o.nand_tree_en}, {dc_exp[7:5], dc_exp[3:0]}, "device fields");
         dg = $random(seed);
         if (k == 2) dg = 8'h00;
         if (k == 3) dg = 8'hff;
         cfg(1'b0, 1'b1, k[1], A_DG, {24'h0, dg});
         rd_chk(k[0], A_DG, {24'h0, dg}, 1'b1);
         check({ctrl_o.id_mask, ctrl_o.csc_route_by_805, ctrl_o.delayed_txn_disable,
                ctrl_o.retry_latency_extend, ctrl_o.card_side_discard_timer_sel,
                ctrl_o.host_side_discard_timer_sel, ctrl_o.async_status_change_irq},
               {dg[7], dg[5:0]}, "diagnostic fields");
         check(retry_latency_o, dg[3] ? 32'd64 : 32'd16, "retry latency");
         check(cb_discard_cycles_o, dg[2] ? 32'd1024 : 32'd32768, "card discard");
         check(pci_discard_cycles_o, dg[1] ? 32'd1024 : 32'd32768, "host discard");
         rd_chk(1'b0, A_ID, dg[7] ? 32'hffff_ffff : true_id_i, 1'b1);
      end
      // A write with the clock enable low leaves the register alone
      @(posedge mclk_i);
      clk_en_i <= 1'b0;
      cfg(1'b0, 1'b1, 1'b0, A_DC, {24'h0, ~dc_exp});
      @(posedge mclk_i);
      clk_en_i <= 1'b1;
      rd_chk(1'b0, A_DC, {24'h0, dc_exp}, 1'b1);
      // Power-down refusal over lock, D3 and request
      for (int i = 0; i < 8; i++) begin
         if (i % 4 == 0) cfg(1'b0, 1'b1, 1'b0, A_DC, {24'h0, i[2], 7'h66});
         @(posedge mclk_i);
         d3_state_i <= i[0];
         sw_power_down_req_i <= i[1];
         @(negedge mclk_i);
         check(socket_power_down_o, i[1] && !(i[0] && i[2]), "power down");
      end
      // Status-change routing source against both compatibility inputs
      for (int i = 0; i < 32; i++) begin
         if (i % 16 == 0) cfg(1'b0, 1'b1, 1'b0, A_DG, {24'h0, 2'b01, i[4], 5'h01});
         @(posedge mclk_i);
         compat803_bit4_i <= i[0];
         compat805_hi_i <= {i[0] & i[3], i[3:1]};
         @(negedge mclk_i);
         check(csc_to_pci_o, exp_csc(i[4], i[0], {i[0] & i[3], i[3:1]}), "csc route");
      end
      // Every pin choice on both sockets, upper bits written with noise
      for (int i = 0; i < 24; i++) begin
         d = $random(seed);
         d[1:0] = i[1:0];
         cfg(1'b0, 1'b1, i[2], A_DMA, d);
         @(posedge mclk_i);
         spk_pin <= $random(seed);
         io16_pin <= $random(seed);
         input_acknowledge_pin_pin <= $random(seed);
         repeat (4) @(posedge mclk_i);
         @(negedge mclk_i);
         check(dma_request_o[i[2]], exp_dma(i[1:0], spk_pin[i[2]], io16_pin[i[2]],
               input_acknowledge_pin_pin[i[2]]), "dma request");
         check({speaker_normal_o[i[2]], io16_normal_o[i[2]], input_acknowledge_pin_normal_o[i[2]]},
               {i[1:0] != 2'h1, i[1:0] != 2'h2, i[1:0] != 2'h3}, "pin normal");
         rd_chk(i[2], A_DMA, {30'h0, i[1:0]}, 1'b1);
      end
      // Mid-run reset brings every register back to its default
      @(posedge mclk_i);
      rst_n_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      rd_chk(1'b0, A_DC, 32'h66, 1'b1);
      rd_chk(1'b0, A_DG, 32'h61, 1'b1);
      rd_chk(1'b1, A_DMA, 32'h0, 1'b1);
      // Retry left unreturned for just under and just over the limit
      @(posedge mclk_i);
      retry_pending_i <= 1'b1;
      repeat (32700) @(posedge mclk_i);
      @(negedge mclk_i);
      check(retry_expired_o, 1'b0, "retry early");
      repeat (100) @(posedge mclk_i);
      @(negedge mclk_i);
      check(retry_expired_o, 1'b1, "retry expired");
      @(posedge mclk_i);
      retry_returned_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      @(negedge mclk_i);
      check(retry_expired_o, 1'b0, "retry cleared");
      tally_and_finish();
   end
endmodule
